// ---- bench/cpu_register_stack_flags_tb_top.sv ----
// self-checking bench for the core register, stack and flag block
`timescale 1ns/1ns
`default_nettype none
`define CRF_CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); \
      fail_count++; \
    end \
  end
module cpu_register_stack_flags_tb_top;
  localparam logic [11:0] RV = 12'h0A5;
  localparam logic [11:0] IV = 12'h3F0;
  localparam logic [11:0] NV = 12'h7FC;
  typedef struct packed {
    logic [7:0]  rdata;
    logic        hit;
    logic [39:0] regs;
    logic [11:0] pc;
    logic [1:0]  bank;
    logic [1:0]  mode;
    logic        carry;
    logic        zero;
    logic [2:0]  depth;
  } crf_snap_type;
  logic                      mclk, rst, acc_we, bank_we, issued, took, s_aw, s_bw;
  logic [7:0]                acc_wdata, s_ad;
  logic [1:0]                bank_wdata, s_bd;
  crf_pkg::crf_dsp_req_type  dsp_req, s_ds;
  crf_pkg::crf_pc_req_type   pc_req, s_pc;
  crf_pkg::crf_flag_req_type flag_req, s_fl;
  logic [11:0]               int_vector, nmi_vector, pc, m_pc;
  logic [7:0]                dsp_rdata, accumulator, first_pointer, second_pointer;
  logic [7:0]                first_short_direct, second_short_direct, m_rdata;
  logic                      dsp_hit, carry_flag, zero_flag, m_hit;
  logic [1:0]                program_bank, m_bank, m_mode;
  crf_pkg::crf_mode_type     mode;
  logic [2:0]                stack_depth, m_depth;
  logic [7:0]                m_reg [5];
  logic [11:0]               m_stk [6];
  logic [1:0]                m_smode [6];
  logic                      m_c [3];
  logic                      m_z [3];
  crf_snap_type              notes [$];
  crf_snap_type              got, exp;
  int                        fail_count, comparisons, cycles;
  logic [15:0]               seed;
  logic [7:0]                dsp_addr [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'h7F, 8'h00};
  crf_pkg::crf_pc_op_type    ops [6] = '{crf_pkg::PC_HOLD, crf_pkg::PC_INC, crf_pkg::PC_JUMP,
                                         crf_pkg::PC_CALL, crf_pkg::PC_REL, crf_pkg::PC_RET};

  crf_vector_model #(.INT_ADDR(IV), .NMI_ADDR(NV)) vectors (.int_vector(int_vector), .nmi_vector(nmi_vector));
  crf_core_regs #(.RESET_VECTOR(RV), .BANK_WIDTH(2)) uut (
    .mclk(mclk), .rst(rst), .dsp_req(dsp_req), .dsp_rdata(dsp_rdata), .dsp_hit(dsp_hit),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .pc_req(pc_req), .int_vector(int_vector),
    .nmi_vector(nmi_vector), .bank_we(bank_we), .bank_wdata(bank_wdata), .flag_req(flag_req),
    .accumulator(accumulator), .first_pointer(first_pointer), .second_pointer(second_pointer),
    .first_short_direct(first_short_direct), .second_short_direct(second_short_direct), .pc(pc),
    .program_bank(program_bank), .carry_flag(carry_flag), .zero_flag(zero_flag), .mode(mode),
    .stack_depth(stack_depth));

  // ****************************************************
  // driver and reference model
  // ****************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int reg_idx(input logic [7:0] a);
    case (a)
      8'h80: return 0;
      8'h81: return 1;
      8'h82: return 2;
      8'h83: return 3;
      8'hFF: return 4;
      default: return 5;
    endcase
  endfunction
  function automatic crf_snap_type model_snap();
    return '{m_rdata, m_hit, {m_reg[4], m_reg[0], m_reg[1], m_reg[2], m_reg[3]}, m_pc, m_bank, m_mode,
             m_c[m_mode], m_z[m_mode], m_depth};
  endfunction
  task automatic clr();
    s_pc = '{crf_pkg::PC_HOLD, 12'h000, 8'h00};
    s_ds = '0;
    s_fl = '0;
    s_aw = 1'b0;
    s_ad = 8'h00;
    s_bw = 1'b0;
    s_bd = 2'h0;
  endtask
  task automatic drive();
    pc_req <= s_pc;
    dsp_req <= s_ds;
    flag_req <= s_fl;
    acc_we <= s_aw;
    acc_wdata <= s_ad;
    bank_we <= s_bw;
    bank_wdata <= s_bd;
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    issued <= 1'b0;
    clr();
    drive();
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    foreach (m_c[i]) begin
      m_c[i] = 1'b0;
      m_z[i] = 1'b0;
    end
    m_pc = RV;
    m_bank = 2'h0;
    m_mode = crf_pkg::MODE_NMI;
    m_depth = 3'h0;
    m_hit = 1'b0;
    m_rdata = 8'h00;
  endtask
  task automatic step();
    int k;
    @(posedge mclk);
    drive();
    issued <= 1'b1;
    k = reg_idx(s_ds.addr);
    m_hit = s_ds.rd && k < 5;
    if (s_ds.rd) m_rdata = m_hit ? m_reg[k] : 8'h00;
    if (s_ds.wr && k < 5) m_reg[k] = s_ds.wdata;
    if (s_aw) m_reg[4] = s_ad;
    if (s_bw) m_bank = s_bd;
    if (s_fl.upd_carry) m_c[m_mode] = s_fl.carry;
    if (s_fl.upd_zero) m_z[m_mode] = s_fl.result == 8'h00;
    case (s_pc.op)
      crf_pkg::PC_INC: m_pc = m_pc + 12'h001;
      crf_pkg::PC_JUMP: m_pc = s_pc.target;
      crf_pkg::PC_REL: m_pc = m_pc + {{4{s_pc.offset[7]}}, s_pc.offset};
      crf_pkg::PC_RESET_VEC: m_pc = RV;
      crf_pkg::PC_CALL, crf_pkg::PC_INT, crf_pkg::PC_NMI: begin
        for (int i = 5; i > 0; i--) begin
          m_stk[i] = m_stk[i-1];
          m_smode[i] = m_smode[i-1];
        end
        m_stk[0] = m_pc;
        m_smode[0] = m_mode;
        if (m_depth < 3'h6) m_depth++;
        m_pc = s_pc.op == crf_pkg::PC_CALL ? s_pc.target : s_pc.op == crf_pkg::PC_INT ? IV : NV;
        if (s_pc.op == crf_pkg::PC_INT) m_mode = crf_pkg::MODE_IRQ;
        if (s_pc.op == crf_pkg::PC_NMI) m_mode = crf_pkg::MODE_NMI;
      end
      crf_pkg::PC_RET, crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION: begin
        if (m_depth == 3'h0) begin
          m_pc = m_pc + 12'h001;
        end else begin
          m_pc = m_stk[0];
          if (s_pc.op == crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION) m_mode = m_smode[0];
          for (int i = 0; i < 5; i++) begin
            m_stk[i] = m_stk[i+1];
            m_smode[i] = m_smode[i+1];
          end
          m_depth--;
        end
      end
      default: ;
    endcase
    notes.push_back(model_snap());
    clr();
  endtask
  task automatic pc_op(input crf_pkg::crf_pc_op_type op, input logic [11:0] t, input logic [7:0] o);
    s_pc = '{op, t, o};
    step();
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************
  // monitor, clock and timeout
  // ****************************************************
  always @(posedge mclk) took <= issued;
  always @(negedge mclk) begin
    if (took === 1'b1 && notes.size() > 0) begin
      got = '{dsp_rdata, dsp_hit, {accumulator, first_pointer, second_pointer, first_short_direct,
              second_short_direct}, pc, program_bank, mode, carry_flag, zero_flag, stack_depth};
      exp = notes.pop_front();
      `CRF_CHECK({got.rdata, got.hit, got.regs}, {exp.rdata, exp.hit, exp.regs})
      `CRF_CHECK({got.pc, got.bank}, {exp.pc, exp.bank})
      `CRF_CHECK({got.mode, got.carry, got.zero}, {exp.mode, exp.carry, exp.zero})
      `CRF_CHECK(got.depth, exp.depth)
    end
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // the whole sequence needs about 125 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    issued = 1'b0;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    seed = 16'h000A;
    clr();
    pc_req = s_pc;
    dsp_req = s_ds;
    flag_req = s_fl;
    acc_we = 1'b0;
    acc_wdata = 8'h00;
    bank_we = 1'b0;
    bank_wdata = 2'h0;
    do_reset();
    step();
    // writes, then reads with a same-cycle write: mapped and unmapped places
    for (int pass = 0; pass < 2; pass++) begin
      foreach (dsp_addr[i]) begin
        seed = lfsr(seed);
        s_ds = '{pass[0], 1'b1, dsp_addr[i], seed[7:0]};
        step();
      end
    end
    // core write beats a data-space write to the accumulator
    s_aw = 1'b1;
    s_ad = 8'h5A;
    s_ds = '{1'b0, 1'b1, 8'hFF, 8'hA5};
    step();
    s_ds = '{1'b1, 1'b0, 8'hFF, 8'h00};
    s_fl = '{1'b1, 1'b1, 1'b1, 8'h00};
    step();
    s_fl = '{1'b0, 1'b0, 1'b1, 8'h01};
    pc_op(crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION, 12'h000, 8'h00);
    pc_op(crf_pkg::PC_RET, 12'h000, 8'h00);
    pc_op(crf_pkg::PC_JUMP, 12'hFFF, 8'h00);
    s_bw = 1'b1;
    s_bd = 2'h3;
    pc_op(crf_pkg::PC_INC, 12'h000, 8'h00);
    pc_op(crf_pkg::PC_REL, 12'h000, 8'h80);
    pc_op(crf_pkg::PC_REL, 12'h000, 8'h7F);
    s_bw = 1'b1;
    s_bd = 2'h1;
    pc_op(crf_pkg::PC_RESET_VEC, 12'h000, 8'h00);
    // seven nested calls overflow six levels, seven returns underflow
    repeat (7) begin
      seed = lfsr(seed);
      pc_op(crf_pkg::PC_CALL, seed[11:0], 8'h00);
    end
    repeat (7) pc_op(crf_pkg::PC_RET, 12'h000, 8'h00);
    // mid-run reset, then nested interrupt entries and exits
    do_reset();
    step();
    pc_op(crf_pkg::PC_INT, 12'h000, 8'h00);
    s_fl = '{1'b1, 1'b1, 1'b1, 8'h00};
    pc_op(crf_pkg::PC_NMI, 12'h000, 8'h00);
    s_fl = '{1'b1, 1'b0, 1'b1, 8'h33};
    pc_op(crf_pkg::PC_CALL, 12'h123, 8'h00);
    pc_op(crf_pkg::PC_RET, 12'h000, 8'h00);
    pc_op(crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION, 12'h000, 8'h00);
    pc_op(crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION, 12'h000, 8'h00);
    // random traffic on every input group at once
    repeat (60) begin
      seed = lfsr(seed);
      s_fl = '{seed[0], seed[1], seed[2], seed[3] ? 8'h00 : seed[15:8]};
      s_ds = '{seed[4], seed[5], dsp_addr[seed[8:6]], seed[15:8]};
      s_aw = seed[9];
      s_ad = seed[7:0];
      s_bw = seed[10];
      s_bd = seed[12:11];
      seed = lfsr(seed);
      pc_op(ops[seed[15:8] % 6], seed[11:0], seed[7:0]);
    end
    clr();
    @(posedge mclk);
    drive();
    issued <= 1'b0;
    repeat (3) @(posedge mclk);
    test_done();
  end
endmodule
`default_nettype wire

// ---- bench/crf_vector_model.sv ----
// program memory stand-in: supplies the interrupt entry addresses
`timescale 1ns/1ns
`default_nettype none
module crf_vector_model #(
  parameter logic [11:0] INT_ADDR = 12'h3F0,
  parameter logic [11:0] NMI_ADDR = 12'h7FC
) (
  output logic [11:0] int_vector,
  output logic [11:0] nmi_vector
);
  // vectors live in program memory, so they never move
  assign int_vector = INT_ADDR;
  assign nmi_vector = NMI_ADDR;
  // routines keep their own flag pairs; nothing is saved here
endmodule
`default_nettype wire

// ---- design/crf_core_regs.sv ----
// programmer-visible core state: data registers, counter, flags, return stack
`timescale 1ns/1ns
`default_nettype none
module crf_core_regs #(
  parameter logic [11:0] RESET_VECTOR = 12'h000,
  parameter int          BANK_WIDTH   = 2
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire crf_pkg::crf_dsp_req_type  dsp_req,
  output logic [7:0]                     dsp_rdata,
  output logic                           dsp_hit,
  input  wire logic                      acc_we,
  input  wire logic [7:0]                acc_wdata,
  input  wire crf_pkg::crf_pc_req_type   pc_req,
  input  wire logic [11:0]               int_vector,
  input  wire logic [11:0]               nmi_vector,
  input  wire logic                      bank_we,
  input  wire logic [BANK_WIDTH-1:0]     bank_wdata,
  input  wire crf_pkg::crf_flag_req_type flag_req,
  output logic [7:0]                     accumulator,
  output logic [7:0]                     first_pointer,
  output logic [7:0]                     second_pointer,
  output logic [7:0]                     first_short_direct,
  output logic [7:0]                     second_short_direct,
  output logic [11:0]                    pc,
  output logic [BANK_WIDTH-1:0]          program_bank,
  output logic                           carry_flag,
  output logic                           zero_flag,
  output crf_pkg::crf_mode_type          mode,
  output logic [2:0]                     stack_depth
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic [11:0]           ret_stack  [crf_pkg::STACK_DEPTH];
  crf_pkg::crf_mode_type mode_stack [crf_pkg::STACK_DEPTH];
  logic [11:0]           next_pc;
  crf_pkg::crf_mode_type next_mode;
  logic                  push;
  logic                  pop;
  logic                  stack_empty;
  logic [2:0]            mode_sel;
  logic [2:0]            pair_carry;
  logic [2:0]            pair_zero;
  logic [2:0]            pair_next_carry;
  logic [2:0]            pair_next_zero;
  logic [11:0]           rel_target;
  logic                  result_zero;
  logic [1:0]            next_idx;
  logic [1:0]            cur_idx;

  // ****************************************************
  // data-space registers
  // ****************************************************
  // the core's own accumulator write wins over a data-space write
  always_ff @(posedge mclk) begin
    if (rst) begin
      accumulator <= crf_pkg::RESET_DATA;
    end else if (acc_we) begin
      accumulator <= acc_wdata;
    end else if (dsp_req.wr && dsp_req.addr == crf_pkg::ADDR_ACCUMULATOR) begin
      accumulator <= dsp_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      first_pointer       <= crf_pkg::RESET_DATA;
      second_pointer      <= crf_pkg::RESET_DATA;
      first_short_direct  <= crf_pkg::RESET_DATA;
      second_short_direct <= crf_pkg::RESET_DATA;
    end else if (dsp_req.wr) begin
      case (dsp_req.addr)
        crf_pkg::ADDR_FIRST_POINTER: begin
          first_pointer <= dsp_req.wdata;
        end
        crf_pkg::ADDR_SECOND_POINTER: begin
          second_pointer <= dsp_req.wdata;
        end
        crf_pkg::ADDR_FIRST_SHORT_DIRECT: begin
          first_short_direct <= dsp_req.wdata;
        end
        crf_pkg::ADDR_SECOND_SHORT_DIRECT: begin
          second_short_direct <= dsp_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read data shows register contents before any same-cycle write
  always_ff @(posedge mclk) begin
    if (rst) begin
      dsp_rdata <= crf_pkg::RESET_DATA;
      dsp_hit   <= 1'b0;
    end else if (dsp_req.rd) begin
      dsp_hit <= 1'b1;
      case (dsp_req.addr)
        crf_pkg::ADDR_FIRST_POINTER:       dsp_rdata <= first_pointer;
        crf_pkg::ADDR_SECOND_POINTER:      dsp_rdata <= second_pointer;
        crf_pkg::ADDR_FIRST_SHORT_DIRECT:  dsp_rdata <= first_short_direct;
        crf_pkg::ADDR_SECOND_SHORT_DIRECT: dsp_rdata <= second_short_direct;
        crf_pkg::ADDR_ACCUMULATOR:         dsp_rdata <= accumulator;
        default: begin
          dsp_rdata <= crf_pkg::RESET_DATA;
          dsp_hit   <= 1'b0;
        end
      endcase
    end else begin
      dsp_hit <= 1'b0;
    end
  end

  // ****************************************************
  // program counter and bank
  // ****************************************************
  always_comb begin
    rel_target  = pc + {{4{pc_req.offset[7]}}, pc_req.offset};
    stack_empty = (stack_depth == crf_pkg::RESET_DEPTH);
    push        = (pc_req.op == crf_pkg::PC_CALL) || (pc_req.op == crf_pkg::PC_INT) ||
                  (pc_req.op == crf_pkg::PC_NMI);
    pop         = ((pc_req.op == crf_pkg::PC_RET) || (pc_req.op == crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION)) && !stack_empty;
    case (pc_req.op)
      crf_pkg::PC_HOLD:      next_pc = pc;
      crf_pkg::PC_INC:       next_pc = pc + crf_pkg::PC_STEP;
      crf_pkg::PC_JUMP:      next_pc = pc_req.target;
      crf_pkg::PC_CALL:      next_pc = pc_req.target;
      crf_pkg::PC_REL:       next_pc = rel_target;
      crf_pkg::PC_INT:       next_pc = int_vector;
      crf_pkg::PC_NMI:       next_pc = nmi_vector;
      crf_pkg::PC_RESET_VEC: next_pc = RESET_VECTOR;
      crf_pkg::PC_RET, crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION: begin
        // empty stack: fall through to the following instruction
        next_pc = stack_empty ? pc + crf_pkg::PC_STEP : ret_stack[0];
      end
      default:               next_pc = pc + crf_pkg::PC_STEP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc <= RESET_VECTOR;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      program_bank <= '0;
    end else if (bank_we) begin
      program_bank <= bank_wdata;
    end
  end

  // ****************************************************
  // return stack with recorded modes
  // ****************************************************
  // no read port to data space; only counter and mode leave it
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < crf_pkg::STACK_DEPTH; i++) begin
        ret_stack[i]  <= crf_pkg::RESET_PC;
        mode_stack[i] <= crf_pkg::MODE_NORMAL;
      end
    end else if (push) begin
      for (int i = crf_pkg::STACK_DEPTH - 1; i > 0; i--) begin
        ret_stack[i]  <= ret_stack[i-1];
        mode_stack[i] <= mode_stack[i-1];
      end
      ret_stack[0]  <= pc;
      mode_stack[0] <= mode;
    end else if (pop) begin
      for (int i = 0; i < crf_pkg::STACK_DEPTH - 1; i++) begin
        ret_stack[i]  <= ret_stack[i+1];
        mode_stack[i] <= mode_stack[i+1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stack_depth <= crf_pkg::RESET_DEPTH;
    end else if (push && stack_depth != crf_pkg::FULL_DEPTH) begin
      stack_depth <= stack_depth + 3'h1;
    end else if (pop) begin
      stack_depth <= stack_depth - 3'h1;
    end
  end

  // ****************************************************
  // mode and flags
  // ****************************************************
  always_comb begin
    case (pc_req.op)
      crf_pkg::PC_INT:  next_mode = crf_pkg::MODE_IRQ;
      crf_pkg::PC_NMI:  next_mode = crf_pkg::MODE_NMI;
      crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION: next_mode = pop ? mode_stack[0] : mode;
      default:          next_mode = mode;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= crf_pkg::MODE_NMI;
    end else begin
      mode <= next_mode;
    end
  end

  always_comb begin
    result_zero = (flag_req.result == 8'h00);
    case (mode)
      crf_pkg::MODE_NORMAL: cur_idx = 2'h0;
      crf_pkg::MODE_IRQ:    cur_idx = 2'h1;
      crf_pkg::MODE_NMI:    cur_idx = 2'h2;
      default:              cur_idx = 2'h0;
    endcase
    case (next_mode)
      crf_pkg::MODE_NORMAL: next_idx = 2'h0;
      crf_pkg::MODE_IRQ:    next_idx = 2'h1;
      crf_pkg::MODE_NMI:    next_idx = 2'h2;
      default:              next_idx = 2'h0;
    endcase
    mode_sel          = 3'h0;
    mode_sel[cur_idx] = 1'b1;
  end

  for (genvar g = 0; g < crf_pkg::MODE_COUNT; g++) begin : g_pair
    crf_flag_pair u_pair (
      .mclk       (mclk),
      .rst        (rst),
      .sel        (mode_sel[g]),
      .upd_carry  (flag_req.upd_carry),
      .carry_in   (flag_req.carry),
      .upd_zero   (flag_req.upd_zero),
      .zero_in    (result_zero),
      .carry      (pair_carry[g]),
      .zero       (pair_zero[g]),
      .next_carry (pair_next_carry[g]),
      .next_zero  (pair_next_zero[g])
    );
  end

  // active flags follow the pair of the mode in force next cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      carry_flag <= crf_pkg::RESET_FLAG;
      zero_flag  <= crf_pkg::RESET_FLAG;
    end else begin
      carry_flag <= pair_next_carry[next_idx];
      zero_flag  <= pair_next_zero[next_idx];
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  reset_nmi_mode_a : assert property (@(posedge mclk) $fell(rst) |-> mode == crf_pkg::MODE_NMI)
    else $error("mode after reset is not nmi");

  pc_increment_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_INC |=> pc == 12'($past(pc) + 12'h001))
    else $error("counter did not step by one");

  call_push_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_CALL |=> ret_stack[0] == $past(pc) && pc == $past(pc_req.target))
    else $error("call did not push and load target");

  ret_pop_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_RET && stack_depth != 3'h0
    |=> pc == $past(ret_stack[0]) && stack_depth == 3'($past(stack_depth) - 3'h1))
    else $error("return did not pop level one");

  depth_saturate_a : assert property (@(posedge mclk) disable iff (rst)
    stack_depth == 3'h6 && pc_req.op == crf_pkg::PC_CALL |=> stack_depth == 3'h6)
    else $error("stack depth passed six");

  empty_return_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION && stack_depth == 3'h0
    |=> pc == 12'($past(pc) + 12'h001) && stack_depth == 3'h0 && mode == $past(mode))
    else $error("exit on empty stack misbehaved");

  irq_entry_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_INT |=> mode == crf_pkg::MODE_IRQ && mode_stack[0] == $past(mode))
    else $error("interrupt entry did not switch mode");

  interrupt_exit_instruction_restore_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_INTERRUPT_EXIT_INSTRUCTION && stack_depth != 3'h0 |=> mode == $past(mode_stack[0]))
    else $error("interrupt exit did not restore mode");

  zero_result_a : assert property (@(posedge mclk) disable iff (rst)
    flag_req.upd_zero && pc_req.op == crf_pkg::PC_INC |=> zero_flag == ($past(flag_req.result) == 8'h00))
    else $error("zero flag does not match result");

  acc_read_a : assert property (@(posedge mclk) disable iff (rst)
    dsp_req.rd && dsp_req.addr == 8'hFF |=> dsp_hit && dsp_rdata == $past(accumulator))
    else $error("accumulator read mismatch");

  acc_core_wins_a : assert property (@(posedge mclk) disable iff (rst)
    acc_we |=> accumulator == $past(acc_wdata))
    else $error("core accumulator write was lost");

  pointer_write_a : assert property (@(posedge mclk) disable iff (rst)
    dsp_req.wr && dsp_req.addr == 8'h81 |=> second_pointer == $past(dsp_req.wdata))
    else $error("second pointer write was lost");

  short_write_a : assert property (@(posedge mclk) disable iff (rst)
    dsp_req.wr && dsp_req.addr == 8'h82 |=> first_short_direct == $past(dsp_req.wdata))
    else $error("first short-direct write was lost");

  bank_write_a : assert property (@(posedge mclk) disable iff (rst)
    bank_we |=> program_bank == $past(bank_wdata))
    else $error("bank write was lost");

  jump_load_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_JUMP |=> pc == $past(pc_req.target))
    else $error("jump did not load target");

  rel_back_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_REL && pc_req.offset[7]
    |=> pc == 12'($past(pc) - {4'h0, 8'(8'h00 - $past(pc_req.offset))}))
    else $error("backward branch target wrong");

  rel_fwd_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_REL && !pc_req.offset[7] |=> pc == 12'($past(pc) + {4'h0, $past(pc_req.offset)}))
    else $error("forward branch target wrong");

  nmi_entry_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_NMI |=> mode == crf_pkg::MODE_NMI && pc == $past(nmi_vector))
    else $error("nmi entry did not switch mode");

  idle_pair_keep_a : assert property (@(posedge mclk) disable iff (rst)
    !mode_sel[0] |=> pair_carry[0] == $past(pair_carry[0]) && pair_zero[0] == $past(pair_zero[0]))
    else $error("idle flag pair changed");

  carry_update_a : assert property (@(posedge mclk) disable iff (rst)
    flag_req.upd_carry && pc_req.op == crf_pkg::PC_INC |=> carry_flag == $past(flag_req.carry))
    else $error("carry flag does not follow update");

  reset_vector_a : assert property (@(posedge mclk) disable iff (rst)
    pc_req.op == crf_pkg::PC_RESET_VEC |=> pc == RESET_VECTOR)
    else $error("reset vector not loaded");

  depth_bound_a : assert property (@(posedge mclk) disable iff (rst) stack_depth <= 3'h6)
    else $error("stack depth out of range");

endmodule
`default_nettype wire

// ---- design/crf_flag_pair.sv ----
// one carry/zero flag pair, updated only while its mode is selected
`timescale 1ns/1ns
`default_nettype none
module crf_flag_pair (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sel,
  input  wire logic upd_carry,
  input  wire logic carry_in,
  input  wire logic upd_zero,
  input  wire logic zero_in,
  output logic      carry,
  output logic      zero,
  output logic      next_carry,
  output logic      next_zero
);

  // unselected pair holds its value untouched
  always_comb begin
    next_carry = (sel && upd_carry) ? carry_in : carry;
    next_zero  = (sel && upd_zero) ? zero_in : zero;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      carry <= crf_pkg::RESET_FLAG;
      zero  <= crf_pkg::RESET_FLAG;
    end else begin
      carry <= next_carry;
      zero  <= next_zero;
    end
  end

endmodule
`default_nettype wire

// ---- design/crf_pkg.sv ----
// constants, types and carriers for the core register, stack and flag block
package crf_pkg;

  // ****************************************************
  // widths and sizes
  // ****************************************************
  localparam int PC_WIDTH    = 12;
  localparam int DATA_WIDTH  = 8;
  localparam int STACK_DEPTH = 6;
  localparam int DEPTH_WIDTH = 3;
  localparam int MODE_COUNT  = 3;

  // ****************************************************
  // data-space addresses
  // ****************************************************
  localparam logic [7:0] ADDR_FIRST_POINTER        = 8'h80;
  localparam logic [7:0] ADDR_SECOND_POINTER       = 8'h81;
  localparam logic [7:0] ADDR_FIRST_SHORT_DIRECT   = 8'h82;
  localparam logic [7:0] ADDR_SECOND_SHORT_DIRECT  = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR          = 8'hFF;

  // ****************************************************
  // reset values, full depth and counter step
  // ****************************************************
  localparam logic [7:0]  RESET_DATA      = 8'h00;
  localparam logic [11:0] RESET_PC        = 12'h000;
  localparam logic        RESET_FLAG      = 1'b0;
  localparam logic [2:0]  RESET_DEPTH     = 3'h0;
  localparam logic [2:0]  FULL_DEPTH      = 3'h6;
  localparam logic [11:0] PC_STEP         = 12'h001;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IRQ,
    MODE_NMI
  } crf_mode_type;

  typedef enum logic [3:0] {
    PC_HOLD,
    PC_INC,
    PC_JUMP,
    PC_CALL,
    PC_REL,
    PC_INT,
    PC_NMI,
    PC_RESET_VEC,
    PC_RET,
    PC_INTERRUPT_EXIT_INSTRUCTION
  } crf_pc_op_type;

  typedef struct packed {
    crf_pc_op_type op;
    logic [11:0]   target;
    logic [7:0]    offset;
  } crf_pc_req_type;

  typedef struct packed {
    logic       upd_carry;
    logic       carry;
    logic       upd_zero;
    logic [7:0] result;
  } crf_flag_req_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crf_dsp_req_type;

endpackage
